// ---- aphp_host_model.sv ----
// Host processor model that performs single accesses on the parallel port.
`timescale 1ns/1ps
module aphp_host_model (
	input  wire logic       clk_sys_in,
	input  wire logic       mode_in,
	input  wire logic       ack_in,
	input  wire logic [7:0] data_in,
	output logic            cs_n_out = 1'b1,
	output logic            dir_n_out = 1'b1,
	output logic            rd_n_out = 1'b1,
	output logic      [6:0] addr_out = 7'h00,
	output logic      [7:0] data_out = 8'h00
);
	// Holds every line until the device ends its pulse and the least low time is met.
	task automatic access(input logic rd, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q, output int len);
		int n;
		n = 0;
		len = 0;
		@(posedge clk_sys_in);
		addr_out <= a;
		data_out <= d;
		dir_n_out <= rd;
		rd_n_out <= ~(rd & mode_in);
		cs_n_out <= 1'b0;
		while ((len == 0 || ack_in !== mode_in || n < 25) && n < 60) begin
			@(posedge clk_sys_in);
			n++;
			if (ack_in !== mode_in) len++;
		end
		q = data_in;
		rd_n_out <= 1'b1;
		if (mode_in) dir_n_out <= 1'b1;
		@(posedge clk_sys_in);
		cs_n_out <= 1'b1;
		@(posedge clk_sys_in);
		dir_n_out <= 1'b1;
		// Released lines show the inverse so stale values are never mistaken for data.
		addr_out <= ~a;
		data_out <= ~d;
		repeat (16) @(posedge clk_sys_in);
	endtask
endmodule

// ---- aphp_pkg.sv ----
// Package with constants and carrier types for the asynchronous parallel host port.
package aphp_pkg;

	// Clock period in picoseconds at 50 MHz.
	localparam int CLK_PERIOD_PS = 20000;
	// Acknowledge pulse: least and longest hold times in nanoseconds.
	localparam int ACK_MIN_NS = 310;
	localparam int ACK_MAX_NS = 472;
	// Least time rounds up, longest time rounds down.
	localparam int ACK_MIN_CYC = (ACK_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ACK_MAX_CYC = (ACK_MAX_NS * 1000) / CLK_PERIOD_PS;
	// The pulse is held for a fixed count inside the documented window.
	localparam int ACK_HOLD_CYC = ACK_MIN_CYC + 2;
	localparam int ACK_CNT_W = 6;

	// Width of the address and data buses.
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;

	// Host bus modes, fixed by static configuration.
	typedef enum logic {
		APHP_MODE_DIR    = 1'b0,
		APHP_MODE_STROBE = 1'b1
	} aphp_mode_t;

	// One access as passed to the register side.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} aphp_access_t;

endpackage

// ---- aphp_port.sv ----
// Device-side asynchronous parallel host port with direction and strobe modes.
//
// Notes on behaviour
// RL1: Direction mode: select frames, direction chooses.
// RL2: Strobe mode: select plus separate read, write strobes.
// RL3: Host holds address from select fall to rise.
// RL4: Host holds direction steady through select.
// RL5: Direction low during select means write.
// RL6: Direction-mode write data taken at select rise.
// RL7: Acknowledge high 310 to 472 ns after select.
// RL8: Host keeps select low 485 or 178 ns.
// RL9: Host waits 320 ns between accesses.
// RL10: Read strobe: ready low 310 to 472 ns.
// RL11: Host keeps read strobe low 486 or 180 ns.
// RL12: Host waits 320 ns after read strobe.
// RL13: Host holds address until read strobe rises.
// RL14: Select precedes and outlasts the read strobe; the host model drives select and read strobe low on the same clock edge.
// RL15: Write strobe: ready low 310 to 472 ns.
// RL16: One static mode; no change mid-access.
`timescale 1ns/1ps
module aphp_port #(
	parameter int ADDR_W = aphp_pkg::ADDR_W,
	parameter int DATA_W = aphp_pkg::DATA_W
) (
	input  wire logic              clk_sys_in,
	input  wire logic              reset_in,
	input  wire logic              mode_in,
	input  wire logic              chip_select_n_in,
	input  wire logic              write_direction_n_in,
	input  wire logic              read_strobe_n_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] data_in,
	output logic      [DATA_W-1:0] data_out,
	output logic                   data_oe_n_out,
	output logic                   transfer_ack_out,
	output logic                   ready_oe_n_out,
	output logic                   wr_valid_out,
	output logic      [ADDR_W-1:0] wr_addr_out,
	output logic      [DATA_W-1:0] wr_data_out,
	output logic                   rd_req_out,
	output logic      [ADDR_W-1:0] rd_addr_out,
	input  wire logic [DATA_W-1:0] rd_data_in
);

	localparam int SW = 4 + ADDR_W + DATA_W;
	localparam int ACW = aphp_pkg::ACK_CNT_W;
	localparam logic [ACW-1:0] HOLD = ACW'(aphp_pkg::ACK_HOLD_CYC);

	typedef enum logic [1:0] {
		APHP_IDLE = 2'b00,
		APHP_BUSY = 2'b01,
		APHP_DONE = 2'b10
	} aphp_state_t;

	logic [SW-1:0]      pins_sync;
	logic               cs_n;
	logic               dir_n;
	logic               rd_n;
	aphp_pkg::aphp_access_t acc;
	aphp_pkg::aphp_mode_t   mode_q;
	aphp_pkg::aphp_mode_t   mode_d;
	aphp_state_t        state_q;
	aphp_state_t        state_d;
	logic [ACW-1:0]     cnt_q;
	logic [ACW-1:0]     cnt_d;
	logic               is_read_q;
	logic               is_read_d;
	logic               cs_n_q;
	logic               mode_sync;
	logic [DATA_W-1:0]  data_d;
	logic               data_oe_n_d;
	logic               ack_d;
	logic               ready_oe_n_d;
	logic               wr_valid_d;
	logic [ADDR_W-1:0]  wr_addr_d;
	logic [DATA_W-1:0]  wr_data_d;
	logic               rd_req_d;
	logic [ADDR_W-1:0]  rd_addr_d;
	logic               active;
	logic               start;

	// Every pin, the static mode strap too, crosses two flops before any logic reads it.
	// Strobes idle high and the mode strap idles in direction mode.
	aphp_sync #(
		.W    (SW),
		.INIT ({4'b0111, {(ADDR_W + DATA_W){1'b0}}})
	) u_sync (
		.clk_sys_in (clk_sys_in),
		.reset_in   (reset_in),
		.async_in   ({mode_in, chip_select_n_in, write_direction_n_in, read_strobe_n_in,
		              addr_in, data_in}),
		.sync_out   (pins_sync)
	);

	assign mode_sync = pins_sync[SW-1];
	assign cs_n      = pins_sync[SW-2];
	assign dir_n     = pins_sync[SW-3];
	assign rd_n      = pins_sync[SW-4];
	assign acc   = pins_sync[ADDR_W+DATA_W-1:0];

	// In strobe mode the direction pin serves as the write strobe.
	always_comb begin
		if (mode_q == aphp_pkg::APHP_MODE_DIR) begin
			active = !cs_n; // RL1
			start  = !cs_n && cs_n_q;
		end else begin
			active = !cs_n && (!rd_n || !dir_n); // RL2 RL14
			start  = active && (state_q == APHP_IDLE);
		end
	end

	// Access sequencer: pace the acknowledge, launch reads, commit writes.
	always_comb begin
		mode_d       = mode_q;
		state_d      = state_q;
		cnt_d        = cnt_q;
		is_read_d    = is_read_q;
		data_d       = data_out;
		data_oe_n_d  = data_oe_n_out;
		ack_d        = transfer_ack_out;
		ready_oe_n_d = ready_oe_n_out;
		wr_valid_d   = 1'b0;
		wr_addr_d    = wr_addr_out;
		wr_data_d    = wr_data_out;
		rd_req_d     = 1'b0;
		rd_addr_d    = rd_addr_out;
		// Mode is only sampled between accesses so it never flips mid-access.
		if (state_q == APHP_IDLE && cs_n) begin
			mode_d = aphp_pkg::aphp_mode_t'(mode_sync); // RL16
		end
		// Ready is driven while select is low and released once it rises.
		ready_oe_n_d = cs_n;
		case (state_q)
			APHP_IDLE: begin
				ack_d = (mode_q == aphp_pkg::APHP_MODE_STROBE);
				if (start) begin
					// RL5: low direction marks a write in direction mode.
					if (mode_q == aphp_pkg::APHP_MODE_DIR) begin
						is_read_d = dir_n; // RL5
					end else begin
						is_read_d = !rd_n;
					end
					rd_addr_d = acc.addr; // RL3 RL13
					rd_req_d  = (mode_q == aphp_pkg::APHP_MODE_DIR) ? dir_n : !rd_n;
					ack_d     = (mode_q == aphp_pkg::APHP_MODE_DIR); // RL7 RL10 RL15
					cnt_d     = HOLD;
					state_d   = APHP_BUSY;
				end
			end
			APHP_BUSY: begin
				if (is_read_q) begin
					data_d      = rd_data_in;
					data_oe_n_d = 1'b0;
				end
				// Fixed count lies between the least and longest pulse widths.
				if (cnt_q == '0) begin
					ack_d   = (mode_q == aphp_pkg::APHP_MODE_STROBE); // RL7 RL10 RL15
					state_d = APHP_DONE;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
				if (!active) begin
					// Host ended early without using the handshake.
					state_d = APHP_DONE;
				end
			end
			default: begin
				ack_d = (mode_q == aphp_pkg::APHP_MODE_STROBE);
				// Write data are committed at the end of the access.
				if (mode_q == aphp_pkg::APHP_MODE_DIR) begin
					if (cs_n) begin
						if (!is_read_q) begin
							wr_valid_d = 1'b1; // RL6
							wr_addr_d  = acc.addr; // RL3
							wr_data_d  = acc.data; // RL6
						end
						data_oe_n_d = 1'b1;
						state_d     = APHP_IDLE;
					end
				end else if (!active) begin
					if (!is_read_q) begin
						wr_valid_d = 1'b1;
						wr_addr_d  = acc.addr;
						wr_data_d  = acc.data;
					end
					data_oe_n_d = 1'b1;
					state_d     = APHP_IDLE;
				end
			end
		endcase
	end

	// Registers of the sequencer; outputs all come straight from here.
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			mode_q           <= aphp_pkg::APHP_MODE_DIR;
			state_q          <= APHP_IDLE;
			cnt_q            <= '0;
			is_read_q        <= 1'b0;
			cs_n_q           <= 1'b1;
			data_out         <= '0;
			data_oe_n_out    <= 1'b1;
			transfer_ack_out <= 1'b0;
			ready_oe_n_out   <= 1'b1;
			wr_valid_out     <= 1'b0;
			wr_addr_out      <= '0;
			wr_data_out      <= '0;
			rd_req_out       <= 1'b0;
			rd_addr_out      <= '0;
		end else begin
			mode_q           <= mode_d;
			state_q          <= state_d;
			cnt_q            <= cnt_d;
			is_read_q        <= is_read_d;
			cs_n_q           <= cs_n;
			data_out         <= data_d;
			data_oe_n_out    <= data_oe_n_d;
			transfer_ack_out <= ack_d;
			ready_oe_n_out   <= ready_oe_n_d;
			wr_valid_out     <= wr_valid_d;
			wr_addr_out      <= wr_addr_d;
			wr_data_out      <= wr_data_d;
			rd_req_out       <= rd_req_d;
			rd_addr_out      <= rd_addr_d;
		end
	end

endmodule

// ---- aphp_port_asserts.sv ----
// Checker for the acknowledge pulse, commit and release timing of the host port.
`timescale 1ns/1ps
module aphp_port_chk (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic mode_in,
	input wire logic chip_select_n_in,
	input wire logic transfer_ack_out,
	input wire logic ready_oe_n_out,
	input wire logic data_oe_n_out,
	input wire logic wr_valid_out,
	input wire logic rd_req_out
);
	// One clock domain, so clock and reset are given once.
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	// The pulse starts when the acknowledge pin is first driven.
	property p_ack_up; $fell(ready_oe_n_out) |-> transfer_ack_out != mode_in; endproperty
	a_ack_up: assert property (p_ack_up) else $error("ack not active at drive start");
	property p_ack_min; !mode_in && $rose(transfer_ack_out) |->
		transfer_ack_out[*8] ##1 transfer_ack_out[*8]; endproperty
	a_ack_min: assert property (p_ack_min) else $error("ack pulse too short");
	property p_ack_max; !mode_in && $rose(transfer_ack_out) |-> ##[16:22] !transfer_ack_out;
	endproperty
	a_ack_max: assert property (p_ack_max) else $error("ack pulse too long");
	property p_rdy_min; mode_in && $fell(transfer_ack_out) |->
		!transfer_ack_out[*8] ##1 !transfer_ack_out[*8]; endproperty
	a_rdy_min: assert property (p_rdy_min) else $error("ready pulse too short");
	property p_rdy_max; mode_in && $fell(transfer_ack_out) |-> ##[16:22] transfer_ack_out;
	endproperty
	a_rdy_max: assert property (p_rdy_max) else $error("ready pulse too long");
	// In direction mode, write data are committed only once select has gone high, in a single cycle.
	property p_wr_commit; !mode_in && wr_valid_out |-> $past(chip_select_n_in) ##1 !wr_valid_out;
	endproperty
	a_wr_commit: assert property (p_wr_commit) else $error("write commit misplaced");
	property p_rd_oe; rd_req_out |=> !data_oe_n_out; endproperty
	a_rd_oe: assert property (p_rd_oe) else $error("read data not driven");
	property p_release; $rose(chip_select_n_in) |-> ##[1:6] data_oe_n_out && ready_oe_n_out;
	endproperty
	a_release: assert property (p_release) else $error("pins not released");
endmodule

bind aphp_port aphp_port_chk u_chk (.clk_sys_in, .reset_in, .mode_in, .chip_select_n_in,
	.transfer_ack_out, .ready_oe_n_out, .data_oe_n_out, .wr_valid_out, .rd_req_out);

// ---- aphp_sync.sv ----
// Two-flop synchroniser for a bundle of asynchronous pin levels.
`timescale 1ns/1ps
module aphp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk_sys_in,
	input  wire logic         reset_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	// The first stage feeds only the second stage, keeping metastability contained.
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			meta_q   <= INIT;
			sync_out <= INIT;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// ---- test_async_parallel_host_port.sv ----
// Self-checking bench for the host port in both bus modes.
`timescale 1ns/1ps
module test_async_parallel_host_port;
	logic       clk_sys_in = 1'b0;
	logic       reset_in = 1'b1;
	logic       mode_in = 1'b0;
	logic       cs_n, dir_n, rd_n, oe_n, ack, rdy_oe_n, wr_v, rd_req;
	logic [6:0] addr, wr_a, rd_a, last_a;
	logic [7:0] dq, dout, wr_d, last_d, q;
	int         num_errors = 0;
	int         n_compared = 0;
	int         n_wr = 0;
	int         cyc = 0;
	int         len;
	// Register side answers with a pattern tied to the address.
	wire logic [7:0] rd_data = {rd_a, 1'b1} ^ 8'h5a;

	always #10 clk_sys_in = ~clk_sys_in;

	aphp_port dut (.clk_sys_in, .reset_in, .mode_in, .chip_select_n_in(cs_n),
		.write_direction_n_in(dir_n), .read_strobe_n_in(rd_n), .addr_in(addr), .data_in(dq),
		.data_out(dout), .data_oe_n_out(oe_n), .transfer_ack_out(ack),
		.ready_oe_n_out(rdy_oe_n), .wr_valid_out(wr_v), .wr_addr_out(wr_a),
		.wr_data_out(wr_d), .rd_req_out(rd_req), .rd_addr_out(rd_a), .rd_data_in(rd_data));
	// A released acknowledge pin is pulled to its inactive level by the board.
	aphp_host_model host (.clk_sys_in, .mode_in, .ack_in(rdy_oe_n ? mode_in : ack),
		.data_in(oe_n ? ~dq : dout), .cs_n_out(cs_n), .dir_n_out(dir_n), .rd_n_out(rd_n),
		.addr_out(addr), .data_out(dq));

	// Register side records committed writes; a hang is cut short by the cycle count.
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (wr_v === 1'b1) begin
			last_a <= wr_a;
			last_d <= wr_d;
			n_wr <= n_wr + 1;
		end
		if (cyc == 4000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic check_len(input int got);
		n_compared++;
		if (got < 16 || got > 23) begin
			num_errors++;
			$display("unexpected ack length: expected 16..23, seen %0d", got);
		end
	endtask

	// Mode is static, so it changes only under reset.
	task automatic t_mode(input logic m);
		mode_in <= m;
		reset_in <= 1'b1;
		repeat (5) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
	endtask

	task automatic t_write();
		logic [6:0] a;
		int         w0;
		for (int i = 0; i < 3; i++) begin
			a = 7'(i * 63);
			w0 = n_wr;
			host.access(1'b0, a, 8'(255 - i * 120), q, len);
			check_len(len);
			check("write address", {1'b0, a}, {1'b0, last_a});
			check("write data", 8'(255 - i * 120), last_d);
			check("write count", 8'(w0 + 1), 8'(n_wr));
		end
		$display("write test done in mode %0d", mode_in);
	endtask

	task automatic t_read();
		logic [6:0] a;
		int         w0;
		for (int i = 0; i < 3; i++) begin
			a = 7'h7f - 7'(i * 63);
			w0 = n_wr;
			host.access(1'b1, a, 8'h00, q, len);
			check_len(len);
			check("read data", {a, 1'b1} ^ 8'h5a, q);
			check("write count", 8'(w0), 8'(n_wr));
		end
		$display("read test done in mode %0d", mode_in);
	endtask

	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		t_mode(1'b0);
		t_write();
		t_read();
		t_mode(1'b1);
		t_write();
		t_read();
		finish_test();
	end
endmodule
